// *** rtl/pixcorr_pkg.sv ***
// Package for the pixel lookup and defect correction stage.
// Assumes one 100 MHz pixel clock and a plain register port.
package pixcorr_pkg;
  localparam int  PIX_W       = 12;
  localparam int  COORD_W     = 12;
  localparam int  LUT_DEPTH   = 4096;
  localparam int  MAP_DEF_MIN = 1024;
  localparam int  MAP_HOT_MIN = 8192;
  localparam real GAMMA_EXP   = 0.45;
  localparam int  ADDR_W      = 8;

  // Register offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_THRESH   = 8'h04;
  localparam logic [7:0] REG_LUT_ADDR = 8'h08;
  localparam logic [7:0] REG_LUT_DATA = 8'h0c;
  localparam logic [7:0] REG_MAP_ADDR = 8'h10;
  localparam logic [7:0] REG_MAP_DATA = 8'h14;
  localparam logic [7:0] REG_STATUS   = 8'h18;

  // Control fields
  localparam int CTRL_DEF_BIT = 0;
  localparam int CTRL_HOT_BIT = 1;
  localparam int CTRL_DYN_BIT = 2;
  localparam int CTRL_SEL_LSB = 3;
  localparam int LUT_TBL_BIT  = 12;
  localparam int STAT_SEL_LSB = 16;

  // Table selection codes, 2'h3 behaves as bypass
  localparam logic [1:0] SEL_BYPASS = 2'h0;
  localparam logic [1:0] SEL_TABLE0 = 2'h1;
  localparam logic [1:0] SEL_TABLE1 = 2'h2;

  // Reset values and threshold ceiling
  localparam logic [4:0]  CTRL_RST   = 5'h00;
  localparam logic [12:0] THRESH_RST = 13'h0040;
  localparam logic [12:0] THRESH_MAX = 13'h1000;

  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [7:0]       addr;
    logic [31:0]      wdata;
  } reg_req_t;

  typedef struct packed {
    logic             valid;
    logic             sof;
    logic             eol;
    logic [11:0]      data;
  } pix_t;

  // One fault map word: valid, hot flag, row and column
  typedef struct packed {
    logic             valid;
    logic             hot;
    logic [1:0]       rsvd_hi;
    logic [11:0]      row;
    logic [3:0]       rsvd_lo;
    logic [11:0]      col;
  } map_entry_t;
endpackage

// *** rtl/lut_table.sv ***
// One 4096 x 12 transfer table with a pixel read port and a host port.
// Assumes synchronous reads; contents are not touched by reset.
`timescale 1ns/1ps
module lut_table #(
  parameter int DEPTH      = pixcorr_pkg::LUT_DEPTH,
  parameter int W          = pixcorr_pkg::PIX_W,
  parameter bit GAMMA_INIT = 1'b0
) (
  // Clock
  input  wire logic                     i_sys_clk,
  // Pixel port
  input  wire logic [$clog2(DEPTH)-1:0] i_pix_addr,
  output logic      [W-1:0]             o_pix_q,
  // Host port
  input  wire logic                     i_host_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_host_addr,
  input  wire logic [W-1:0]             i_host_wdata,
  output logic      [W-1:0]             o_host_q
);
  import pixcorr_pkg::*;

  logic [W-1:0] mem [DEPTH];

  // Factory gamma curve, or an empty table until software loads one
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      if (GAMMA_INIT) begin
        mem[i] = W'($rtoi((2.0 ** W - 1.0) *
                 ((real'(i) / real'(DEPTH - 1)) ** GAMMA_EXP) + 0.5));
      end else begin
        mem[i] = '0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_host_we) begin
      mem[i_host_addr] <= i_host_wdata; // RULE_05
    end
    o_pix_q  <= mem[i_pix_addr]; // RULE_01
    o_host_q <= mem[i_host_addr];
  end
endmodule

// *** rtl/pixel_lut_defect_correction.sv ***
// Pixel stage: static map, dynamic defect correction, then table lookup.
// Assumes a pixel stream with sof on the first and eol on each last pixel.
`timescale 1ns/1ps
// Operation
// RULE_01: Lookup maps every 12-bit pixel to any 12-bit value of the table.
// RULE_02: Two independent tables, 4096 entries of 12 bits, indexed by pixel.
// RULE_03: First table starts as gamma 0.45 curve; second starts empty.
// RULE_04: With gamma table active every pixel passes the gamma mapping.
// RULE_05: Host uploads may overwrite both tables, gamma one included.
// RULE_06: Host must upload all codes 0 to 4095 with no gaps.
// RULE_07: Each fault map entry names one pixel by row and column.
// RULE_08: Defect correction fixes pixels whose coordinates match an entry.
// RULE_09: Hot correction fixes pixels matching a hot entry of the map.
// RULE_10: The map holds at least 1024 defective pixel entries.
// RULE_11: The map holds at least 8192 hot pixel entries.
// RULE_12: Map is loaded from storage, replaceable by upload, readable back.
// RULE_13: Dynamic correction compares each pixel to neighbours both ways.
// RULE_14: Threshold 0 to 4096; deviation above it marks pixel defective.
// RULE_15: Static defect, hot and dynamic enables act independently.
// RULE_16: A user map may replace the factory map in the field.
// RULE_17: Corrected pixels take the same-colour neighbour average.
// RULE_18: Table choice or bypass is selected; it changes only at frame start.
module pixel_lut_defect_correction
  import pixcorr_pkg::*;
#(
  parameter int MAP_DEPTH = MAP_DEF_MIN + MAP_HOT_MIN // RULE_10 RULE_11
) (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  // Register port
  input  wire pixcorr_pkg::reg_req_t i_req,
  output logic [31:0]            o_rdata,
  // Pixel stream
  input  wire pixcorr_pkg::pix_t i_pix,
  output pixcorr_pkg::pix_t      o_pix
);
  import pixcorr_pkg::*;

  localparam int MAP_AW = $clog2(MAP_DEPTH);

  generate
    if (MAP_DEPTH < MAP_DEF_MIN + MAP_HOT_MIN) begin : g_bad_depth
      $error("MAP_DEPTH too small for defect plus hot entries");
    end
  endgenerate

  typedef struct packed {
    pix_t px;
    logic fix;
  } tap_t;

  // Register state
  logic [4:0]        ctrl,     next_ctrl;
  logic [12:0]       thresh,   next_thresh;
  logic [12:0]       lut_addr, next_lut_addr;
  logic [MAP_AW-1:0] map_addr, next_map_addr;
  logic [31:0]       rdata,    next_rdata;
  // Fault map state
  map_entry_t        map_mem [MAP_DEPTH];
  map_entry_t        map_q, map_rd_q, first_ent, next_first_ent;
  logic [MAP_AW-1:0] ptr,      next_ptr;
  logic [COORD_W-1:0] row,     next_row;
  logic [COORD_W-1:0] col,     next_col;
  // Pipeline state
  tap_t              sr [5];
  tap_t              next_sr [5];
  pix_t              c_pix,    next_c_pix;
  pix_t              d1,       next_d1;
  logic [1:0]        act_sel,  next_act_sel;
  logic [1:0]        sel1,     next_sel1;
  pix_t              out_pix,  next_out_pix;
  // Combinational helpers
  logic              lut_we, map_we;
  logic [11:0]       q0, q1, hq0, hq1;
  map_entry_t        ent;
  logic [COORD_W-1:0] cur_row, cur_col;
  logic              match, behind, fix_static;
  logic [11:0]       n_a, n_b, ctr, hi, lo;
  logic [13:0]       hi_lim, ctr_lim;
  logic              dyn_fix, fix_any;
  logic [12:0]       nsum;
  logic [1:0]        eff_sel;

  // Register port
  always_comb begin
    next_ctrl     = ctrl;
    next_thresh   = thresh;
    next_lut_addr = lut_addr;
    next_map_addr = map_addr;
    next_rdata    = 32'h0000_0000;
    lut_we        = 1'b0;
    map_we        = 1'b0;
    if (i_req.wr) begin
      unique case (i_req.addr)
        REG_CTRL:     next_ctrl = i_req.wdata[4:0]; // RULE_15
        REG_THRESH:   next_thresh = (i_req.wdata > 32'(THRESH_MAX)) ?
                        THRESH_MAX : i_req.wdata[12:0]; // RULE_14
        REG_LUT_ADDR: next_lut_addr = i_req.wdata[12:0];
        REG_LUT_DATA: begin
          lut_we        = 1'b1; // RULE_05
          next_lut_addr = lut_addr + 13'h0001;
        end
        REG_MAP_ADDR: next_map_addr = i_req.wdata[MAP_AW-1:0];
        REG_MAP_DATA: begin
          map_we        = 1'b1; // RULE_16
          next_map_addr = map_addr + MAP_AW'(1);
        end
        default: ;
      endcase
    end
    if (i_req.rd) begin
      unique case (i_req.addr)
        REG_CTRL:     next_rdata = 32'(ctrl);
        REG_THRESH:   next_rdata = 32'(thresh);
        REG_LUT_ADDR: next_rdata = 32'(lut_addr);
        REG_LUT_DATA: next_rdata = 32'(lut_addr[LUT_TBL_BIT] ? hq1 : hq0);
        REG_MAP_ADDR: next_rdata = 32'(map_addr);
        REG_MAP_DATA: next_rdata = map_rd_q; // RULE_12
        REG_STATUS:   next_rdata = 32'(ptr) |
                        (32'(act_sel) << STAT_SEL_LSB);
        default:      next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl     <= CTRL_RST;
      thresh   <= THRESH_RST;
      lut_addr <= '0;
      map_addr <= '0;
      rdata    <= 32'h0000_0000;
    end else begin
      ctrl     <= next_ctrl;
      thresh   <= next_thresh;
      lut_addr <= next_lut_addr;
      map_addr <= next_map_addr;
      rdata    <= next_rdata;
    end
  end

  assign o_rdata = rdata;

  // Map is a RAM filled from non-volatile storage by the boot loader
  always_ff @(posedge i_sys_clk) begin
    if (map_we) begin
      map_mem[map_addr] <= map_entry_t'(i_req.wdata); // RULE_12
    end
    map_q    <= map_mem[next_ptr];
    map_rd_q <= map_mem[map_addr];
  end

  // Static match; entries must be sorted in raster order
  always_comb begin
    cur_row        = i_pix.sof ? '0 : row;
    cur_col        = i_pix.sof ? '0 : col;
    ent            = i_pix.sof ? first_ent : map_q;
    match          = i_pix.valid && ent.valid &&
                     ent.row == cur_row && ent.col == cur_col; // RULE_07
    behind         = i_pix.valid && ent.valid &&
                     {ent.row, ent.col} < {cur_row, cur_col};
    fix_static     = match && (ent.hot ? ctrl[CTRL_HOT_BIT]
                                       : ctrl[CTRL_DEF_BIT]); // RULE_08
    next_first_ent = (map_we && map_addr == '0) ?
                     map_entry_t'(i_req.wdata) : first_ent;
    next_ptr       = ptr;
    next_row       = row;
    next_col       = col;
    if (i_pix.valid) begin
      next_ptr = i_pix.sof ? '0 : ptr;
      // Skipping late entries lets the walk recover from unsorted maps
      if ((match || behind) && next_ptr != MAP_AW'(MAP_DEPTH - 1)) begin
        next_ptr = next_ptr + MAP_AW'(1); // RULE_09
      end
      next_row = i_pix.eol ? cur_row + COORD_W'(1) : cur_row;
      next_col = i_pix.eol ? '0 : cur_col + COORD_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr       <= '0;
      row       <= '0;
      col       <= '0;
      first_ent <= '0;
    end else begin
      ptr       <= next_ptr;
      row       <= next_row;
      col       <= next_col;
      first_ent <= next_first_ent;
    end
  end

  // Neighbour window: same-colour pixels sit two apart in a Bayer line
  always_comb begin
    n_a     = sr[0].px.data;
    n_b     = sr[4].px.data;
    ctr     = sr[2].px.data;
    hi      = (n_a > n_b) ? n_a : n_b;
    lo      = (n_a > n_b) ? n_b : n_a;
    hi_lim  = 14'(hi) + 14'(thresh);
    ctr_lim = 14'(ctr) + 14'(thresh);
    dyn_fix = ctrl[CTRL_DYN_BIT] &&
              (14'(ctr) > hi_lim || ctr_lim < 14'(lo)); // RULE_13
    fix_any = sr[2].fix || dyn_fix; // RULE_15
    nsum    = 13'(n_a) + 13'(n_b);
    next_c_pix       = c_pix;
    next_c_pix.valid = 1'b0;
    for (int i = 0; i < 5; i++) begin
      next_sr[i] = sr[i];
    end
    if (i_pix.valid) begin
      next_sr[0] = '{px: i_pix, fix: fix_static};
      for (int i = 1; i < 5; i++) begin
        next_sr[i] = sr[i - 1];
      end
      next_c_pix      = sr[2].px;
      next_c_pix.data = fix_any ? nsum[12:1] : ctr; // RULE_17
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 5; i++) begin
        sr[i] <= '0;
      end
      c_pix <= '0;
    end else begin
      sr    <= next_sr;
      c_pix <= next_c_pix;
    end
  end

  // Lookup tables
  lut_table #(.GAMMA_INIT(1'b1)) u_table0 ( // RULE_03
    .i_sys_clk   (i_sys_clk),
    .i_pix_addr  (c_pix.data),
    .o_pix_q     (q0),
    .i_host_we   (lut_we && !lut_addr[LUT_TBL_BIT]),
    .i_host_addr (lut_addr[11:0]),
    .i_host_wdata(i_req.wdata[11:0]),
    .o_host_q    (hq0)
  );

  lut_table #(.GAMMA_INIT(1'b0)) u_table1 ( // RULE_02
    .i_sys_clk   (i_sys_clk),
    .i_pix_addr  (c_pix.data),
    .o_pix_q     (q1),
    .i_host_we   (lut_we && lut_addr[LUT_TBL_BIT]),
    .i_host_addr (lut_addr[11:0]),
    .i_host_wdata(i_req.wdata[11:0]),
    .o_host_q    (hq1)
  );

  // Selection is sampled with the frame's first pixel so no frame mixes
  always_comb begin
    eff_sel = (c_pix.valid && c_pix.sof) ?
              ctrl[CTRL_SEL_LSB +: 2] : act_sel; // RULE_18
    next_act_sel = eff_sel;
    next_sel1    = eff_sel;
    next_d1      = c_pix;
    next_out_pix = d1;
    unique case (sel1)
      SEL_TABLE0: next_out_pix.data = q0; // RULE_04
      SEL_TABLE1: next_out_pix.data = q1; // RULE_01
      default:    next_out_pix.data = d1.data;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act_sel <= SEL_BYPASS;
      sel1    <= SEL_BYPASS;
      d1      <= '0;
      out_pix <= '0;
    end else begin
      act_sel <= next_act_sel;
      sel1    <= next_sel1;
      d1      <= next_d1;
      out_pix <= next_out_pix;
    end
  end

  assign o_pix = out_pix;

  // Checks
  sequence s_thr_write;
    i_req.wr && i_req.addr == REG_THRESH;
  endsequence

  AST_THR_LIMIT: assert property ( // RULE_14
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_thr_write ##1 1'b1 |-> thresh <= THRESH_MAX)
    else $error("threshold above 4096");

  AST_SEL_FRAME: assert property ( // RULE_18
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    $changed(act_sel) |-> $past(c_pix.valid) && $past(c_pix.sof))
    else $error("table selection changed inside a frame");

  AST_STATIC_FIX: assert property ( // RULE_08
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    match && !ent.hot && ctrl[CTRL_DEF_BIT] |=> sr[0].fix)
    else $error("matched defect pixel not flagged");

  AST_HOT_OFF: assert property ( // RULE_09
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    match && ent.hot && !ctrl[CTRL_HOT_BIT] |=> !sr[0].fix)
    else $error("hot pixel flagged while hot correction off");

  AST_MAP_ADVANCE: assert property ( // RULE_07
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    match && !i_pix.sof && ptr != MAP_AW'(MAP_DEPTH - 1)
    |=> ptr == $past(ptr) + MAP_AW'(1))
    else $error("map pointer did not advance on match");

  AST_PASS_THROUGH: assert property ( // RULE_17
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_pix.valid && !fix_any |=> c_pix.data == $past(ctr))
    else $error("uncorrected pixel was altered");

  AST_DYN_DETECT: assert property ( // RULE_13
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_pix.valid && ctrl[CTRL_DYN_BIT] && 14'(ctr) > hi_lim
    |=> c_pix.data == $past(nsum[12:1]))
    else $error("bright outlier not replaced");

  sequence s_bypass_pixel;
    c_pix.valid && eff_sel == SEL_BYPASS ##1 1'b1;
  endsequence

  AST_BYPASS_LATENCY: assert property ( // RULE_18
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_bypass_pixel |=> o_pix.valid && o_pix.data == $past(c_pix.data, 2))
    else $error("bypass pixel not delivered after two cycles");

  AST_RDATA_IDLE: assert property ( // RULE_12
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_req.rd |=> o_rdata == 32'h0000_0000)
    else $error("read data present without a read");
endmodule

// *** tb/pixel_stream_peer.sv ***
// Upstream pixel source and downstream sink for the pixel stage.
// Assumes the bench fills img before send_frame and reads got after.
`timescale 1ns/1ps
module pixel_stream_peer (
  // Clock
  input  wire logic              i_sys_clk,
  // Stream towards and back from the stage
  output pixcorr_pkg::pix_t      o_pix,
  input  wire pixcorr_pkg::pix_t i_pix
);
  import pixcorr_pkg::*;
  logic [11:0] img[$];
  logic [11:0] got[$];
  int          eols;

  initial o_pix = '0;

  // Three pad pixels push the last real pixels out of the window
  task automatic send_frame(input int w);
    for (int i = 0; i < img.size() + 3; i++) begin
      @(posedge i_sys_clk);
      o_pix.valid <= 1'b1;
      o_pix.sof   <= (i == 0);
      o_pix.eol   <= (i % w == w - 1);
      o_pix.data  <= (i < img.size()) ? img[i] : img[0];
    end
    // Idle data is scrambled so a stale pixel can never pass for a new one
    @(posedge i_sys_clk);
    o_pix <= '{1'b0, 1'b0, 1'b0, ~o_pix.data};
  endtask

  // Output collection restarts at each output frame start
  always @(posedge i_sys_clk) begin
    if (i_pix.valid) begin
      if (i_pix.sof) begin
        got = {};
        eols = 0;
      end
      got.push_back(i_pix.data);
      if (i_pix.eol)
        eols++;
    end
  end
endmodule

// *** tb/tb_pixel_lut_defect_correction.sv ***
// Self-checking bench for the pixel lookup and defect correction stage.
// Assumes the peer model drives the pixel stream and records the output.
`timescale 1ns/1ps
module tb_pixel_lut_defect_correction;
  import pixcorr_pkg::*;
  logic        i_sys_clk;
  logic        i_rst_n;
  reg_req_t    req;
  logic [31:0] rdata;
  pix_t        pin;
  pix_t        pout;
  int          err_count;
  int          tests_run;
  int          exp[$];

  pixel_lut_defect_correction dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req(req),
    .o_rdata(rdata), .i_pix(pin), .o_pix(pout));
  pixel_stream_peer peer (
    .i_sys_clk(i_sys_clk), .o_pix(pin), .i_pix(pout));

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge i_sys_clk);
    req.wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge i_sys_clk);
    req.rd <= 1'b0;
    @(posedge i_sys_clk);
    d = rdata;
  endtask

  task automatic chk_frame(input string n, input int w);
    peer.send_frame(w);
    repeat (12) @(posedge i_sys_clk);
    chk({n, " count"}, exp.size(), peer.got.size());
    chk({n, " lines"}, exp.size() / w, peer.eols);
    foreach (exp[i])
      if (exp[i] >= 0)
        chk(n, exp[i], peer.got[i]);
  endtask

  function automatic int lut_val(input int s, input int v);
    if (s == 1)
      return 4095 - v;
    if (s == 2)
      return v ^ 12'ha5a;
    return v;
  endfunction

  task automatic test_regs();
    logic [31:0] d;
    reg_rd(REG_CTRL, d);
    chk("ctrl reset", 32'h0, d);
    reg_rd(REG_THRESH, d);
    chk("thresh reset", 32'h40, d);
    reg_wr(REG_THRESH, 32'h1fff);
    reg_rd(REG_THRESH, d);
    chk("thresh max", 32'h1000, d);
    reg_wr(REG_CTRL, 32'hffffffe7);
    reg_rd(REG_CTRL, d);
    chk("ctrl fields", 32'h7, d);
    reg_wr(8'h40, 32'h1234);
    reg_rd(8'h40, d);
    chk("unmapped", 32'h0, d);
    $display("test regs done");
  endtask

  task automatic test_lut();
    logic [31:0] d;
    peer.img = {};
    exp = {};
    for (int i = 0; i < 64; i++) begin
      peer.img.push_back(12'(i * 65));
      exp.push_back((i == 0) ? 0 : (i == 63) ? 4095 : -1);
    end
    reg_wr(REG_CTRL, 32'h08);
    chk_frame("gamma ends", 16);
    // Fill both tables in full, so no code is left undefined
    for (int t = 0; t < 2; t++) begin
      reg_wr(REG_LUT_ADDR, 32'(t) << 12);
      for (int i = 0; i < LUT_DEPTH; i++)
        reg_wr(REG_LUT_DATA, 32'(lut_val(t + 1, i)));
    end
    reg_wr(REG_LUT_ADDR, 32'h1005);
    reg_rd(REG_LUT_DATA, d);
    chk("lut readback", 32'(5 ^ 12'ha5a), d);
    for (int s = 0; s < 4; s++) begin
      reg_wr(REG_CTRL, 32'(s) << 3);
      foreach (exp[i])
        exp[i] = lut_val(s, i * 65);
      chk_frame("lut map", 16);
      reg_rd(REG_STATUS, d);
      chk("active sel", 32'(s), 32'(d[17:16]));
    end
    $display("test lut done");
  endtask

  task automatic test_map();
    logic [31:0] d;
    reg_wr(REG_MAP_ADDR, 32'h0);
    reg_wr(REG_MAP_DATA, 32'h80000006);
    reg_wr(REG_MAP_DATA, 32'hc0010004);
    reg_wr(REG_MAP_DATA, 32'h0);
    reg_wr(REG_MAP_ADDR, 32'h0);
    reg_rd(REG_MAP_DATA, d);
    chk("map readback", 32'h80000006, d);
    peer.img = {};
    for (int i = 0; i < 24; i++)
      peer.img.push_back((i == 6 || i == 16) ? 12'd3000 : 12'd800);
    for (int en = 1; en < 4; en++) begin
      reg_wr(REG_CTRL, 32'(en));
      exp = {};
      foreach (peer.img[i])
        exp.push_back(int'(peer.img[i]));
      exp[6] = en[0] ? 800 : 3000;
      exp[16] = en[1] ? 800 : 3000;
      chk_frame("static fix", 12);
    end
    reg_rd(REG_STATUS, d);
    chk("map ptr", 32'h2, d & 32'h3fff);
    $display("test map done");
  endtask

  task automatic test_dyn();
    reg_wr(REG_THRESH, 32'd100);
    reg_wr(REG_CTRL, 32'h4);
    peer.img = {};
    for (int i = 0; i < 40; i++)
      peer.img.push_back(12'd1000);
    peer.img[8] = 12'd1100;
    peer.img[16] = 12'd1101;
    peer.img[24] = 12'd899;
    peer.img[32] = 12'd900;
    exp = {};
    foreach (peer.img[i])
      exp.push_back(int'(peer.img[i]));
    // First two pixels see the previous frame's tail as neighbours
    exp[0] = -1;
    exp[1] = -1;
    exp[16] = 1000;
    exp[24] = 1000;
    chk_frame("dynamic fix", 40);
    $display("test dynamic done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // The table fills take about 17000 cycles; allow about three times that
  initial begin
    #500_000;
    err_count++;
    finish_test();
  end

  initial begin
    err_count = 0;
    tests_run = 0;
    i_rst_n = 1'b0;
    req = '0;
    repeat (10) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    test_regs();
    test_lut();
    test_map();
    test_dyn();
    finish_test();
  end
endmodule
